// File: core/sam_pkg.sv
`default_nettype none
package sam_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SAMPLE_PERIOD_US = 1000;
  localparam int unsigned SAMPLE_CYCLES = (CLK_HZ / 1_000_000) * SAMPLE_PERIOD_US;
  localparam int unsigned APB_AW = 12;
  localparam logic [11:0] OFS_MAXSPD = 12'h000;
  localparam logic [11:0] OFS_ACCEL = 12'h004;
  localparam logic [11:0] OFS_DECEL = 12'h008;
  localparam logic [11:0] OFS_TARGET = 12'h00C;
  localparam logic [11:0] OFS_CMD = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_POS = 12'h018;
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_OP_MSB = 3;
  localparam int unsigned CMD_DIR_BIT = 4;
  localparam int unsigned CMD_LDMAX_BIT = 5;
  localparam int unsigned CMD_LDACC_BIT = 6;
  localparam int unsigned CMD_CLRF_BIT = 8;
  localparam int unsigned ST_RUN_BIT = 0;
  localparam int unsigned ST_DIR_BIT = 1;
  localparam int unsigned ST_FAULT_BIT = 2;
  localparam int unsigned ST_PROF_BIT = 3;
  localparam int unsigned ST_STOPPING_BIT = 4;
  localparam int unsigned ST_MODE_LSB = 5;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [3:0]
  {
    OP_NONE = 4'h0,
    OP_PROFILE = 4'h1,
    OP_ABS = 4'h2,
    OP_REL = 4'h3,
    OP_VEL = 4'h4,
    OP_HOME = 4'h5,
    OP_SOFT = 4'h6,
    OP_HARD = 4'h7,
    OP_ZERO = 4'h8
  } sam_op_e;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_POS = 2'b01,
    ST_VEL = 2'b10,
    ST_HOME = 2'b11
  } sam_state_e;
endpackage
`default_nettype wire

// File: core/sam_tick.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Periodic sampling tick.
// ----------------------------------------
module sam_tick
  import sam_pkg::*;
#(
  parameter int unsigned CYCLES = SAMPLE_CYCLES
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  output logic tick_o
);
  logic [31:0] count;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (count == 32'(CYCLES - 1));
      if (count == 32'(CYCLES - 1))
        count <= '0;
      else
        count <= count + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// File: core/sam_rate_acc.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Fractional rate accumulator, one event per MODULUS of summed increments.
// ----------------------------------------
module sam_rate_acc
  import sam_pkg::*;
#(
  parameter int unsigned INC_W = 24,
  parameter int unsigned MODULUS = CLK_HZ
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clear_i,
  input wire logic [INC_W-1:0] inc_i,
  output logic ovf_o
);
  logic [32:0] acc;
  logic [32:0] sum;

  assign sum = acc + 33'(inc_i);
  assign ovf_o = ~clear_i & (sum >= 33'(MODULUS));

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      acc <= '0;
    else if (clear_i)
      acc <= '0;
    else if (ovf_o)
      acc <= sum - 33'(MODULUS);
    else
      acc <= sum;
  end
endmodule
`default_nettype wire

// File: core/sam_axis.sv
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sam_axis
  import sam_pkg::*;
#(
  parameter int unsigned SPD_W = 24,
  parameter int unsigned POS_W = 32,
  parameter int unsigned TICK_CYCLES = SAMPLE_CYCLES,
  parameter int unsigned STEP_CLK_HZ = CLK_HZ
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic home_i,
  input wire logic fwd_limit_i,
  input wire logic rev_limit_i,
  input wire logic soft_stop_i,
  output logic step_o,
  output logic dir_o
);
  // ----------------------------------------
  // Declarations.
  // ----------------------------------------
  logic [SPD_W-1:0] stage_max, stage_acc, max_spd, accel, decel, speed, ramp_inc;
  logic signed [POS_W-1:0] position, target;
  logic signed [POS_W:0] delta;
  logic [POS_W:0] abs_mag;
  logic [POS_W-1:0] remaining;
  logic [63:0] spd_sq, stop_dist;
  logic [31:0] rd_data;
  sam_state_e state;
  sam_op_e op;
  logic profiled, fault, stopping, home_start, tick, ramp_ovf, step_ovf, acc_go, wr_go, cmd_go;
  logic mapped, running, is_move, new_dir, blocked, start_ok, hard_cmd, limit_hit, home_hit;
  logic abort, step_go, pos_done, soft_done, end_now, soft_req, decel_now, floor_one, zero_ok;
  // ----------------------------------------
  // Helper blocks.
  // ----------------------------------------
  sam_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tick_o(tick)
  );

  sam_rate_acc #(
    .INC_W(SPD_W),
    .MODULUS(STEP_CLK_HZ)
  ) u_ramp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .clear_i(~running),
    .inc_i(ramp_inc),
    .ovf_o(ramp_ovf)
  );

  sam_rate_acc #(
    .INC_W(SPD_W),
    .MODULUS(STEP_CLK_HZ)
  ) u_step (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .clear_i(~running),
    .inc_i(speed),
    .ovf_o(step_ovf)
  );

  // ----------------------------------------
  // Bus decode, command decode, stop sources and ramp decision.
  // ----------------------------------------
  assign acc_go = psel_i & penable_i & pready_o;
  assign wr_go = acc_go & pwrite_i;
  assign cmd_go = wr_go & (paddr_i == OFS_CMD);
  assign op = sam_op_e'(pwdata_i[CMD_OP_MSB:CMD_OP_LSB]);
  assign running = (state != ST_IDLE);
  assign is_move = (op == OP_ABS) | (op == OP_REL) | (op == OP_VEL) | (op == OP_HOME);
  assign delta = {target[POS_W-1], target} - {position[POS_W-1], position};
  assign abs_mag = delta[POS_W] ? -delta : delta;
  assign new_dir = (op == OP_ABS) ? ~delta[POS_W] :
                   (op == OP_HOME) ? home_i : pwdata_i[CMD_DIR_BIT];
  assign blocked = new_dir ? fwd_limit_i : rev_limit_i;
  assign start_ok = cmd_go & is_move & profiled & ~running & ~blocked
                    & ~((op == OP_ABS) & (delta == '0))
                    & ~((op == OP_REL) & (target == '0));
  assign zero_ok = cmd_go & (op == OP_ZERO) & ~running;
  assign hard_cmd = cmd_go & (op == OP_HARD) & running;
  assign limit_hit = running & (dir_o ? fwd_limit_i : rev_limit_i);
  assign home_hit = (state == ST_HOME) & tick & (home_i != home_start);
  assign abort = hard_cmd | limit_hit | home_hit;
  assign step_go = running & step_ovf & ~abort;
  assign pos_done = (state == ST_POS) & step_go & (remaining == 1);
  assign soft_done = stopping & (speed == '0);
  assign end_now = abort | pos_done | soft_done;
  assign soft_req = running & ((cmd_go & (op == OP_SOFT))
                    | (soft_stop_i & (state != ST_HOME)));
  assign spd_sq = 64'(speed) * 64'(speed);
  assign stop_dist = 64'(decel) * 64'(remaining) * 64'h2;
  assign floor_one = (state == ST_POS) & ~stopping;
  assign decel_now = stopping | (speed > max_spd)
                     | ((state == ST_POS) & (spd_sq >= stop_dist));
  assign ramp_inc = decel_now ? decel : accel;

  // ----------------------------------------
  // Bus response.
  // ----------------------------------------
  assign mapped = (paddr_i == OFS_MAXSPD) | (paddr_i == OFS_ACCEL) | (paddr_i == OFS_DECEL)
                  | (paddr_i == OFS_TARGET) | (paddr_i == OFS_CMD)
                  | (paddr_i == OFS_STATUS) | (paddr_i == OFS_POS);

  always_comb
  begin
    rd_data = RST_WORD;
    unique case (paddr_i)
      OFS_MAXSPD: rd_data = 32'(max_spd);
      OFS_ACCEL: rd_data = 32'(accel);
      OFS_DECEL: rd_data = 32'(decel);
      OFS_TARGET: rd_data = 32'(target);
      OFS_STATUS:
      begin
        rd_data[ST_RUN_BIT] = running;
        rd_data[ST_DIR_BIT] = dir_o;
        rd_data[ST_FAULT_BIT] = fault;
        rd_data[ST_PROF_BIT] = profiled;
        rd_data[ST_STOPPING_BIT] = stopping;
        rd_data[ST_MODE_LSB+1:ST_MODE_LSB] = state;
      end
      OFS_POS: rd_data = 32'(position);
      default: rd_data = RST_WORD;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= RST_WORD;
    end
    else
    begin
      pready_o <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
      if (psel_i & penable_i & ~pready_o & ~pwrite_i)
        prdata_o <= rd_data;
    end
  end

  // ----------------------------------------
  // Profile and target registers.
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stage_max <= '0;
      stage_acc <= '0;
      max_spd <= '0;
      accel <= '0;
      decel <= '0;
      target <= '0;
      profiled <= 1'b0;
    end
    else
    begin
      if (wr_go & (paddr_i == OFS_MAXSPD))
        stage_max <= pwdata_i[SPD_W-1:0];
      if (wr_go & (paddr_i == OFS_ACCEL))
        stage_acc <= pwdata_i[SPD_W-1:0];
      if (wr_go & (paddr_i == OFS_DECEL))
        decel <= pwdata_i[SPD_W-1:0];
      if (wr_go & (paddr_i == OFS_TARGET))
        target <= pwdata_i[POS_W-1:0];
      if (cmd_go & (op == OP_PROFILE))
      begin
        profiled <= 1'b1;
        if (pwdata_i[CMD_LDMAX_BIT])
          max_spd <= stage_max;
        if (pwdata_i[CMD_LDACC_BIT])
        begin
          accel <= stage_acc;
          decel <= stage_acc;
        end
      end
    end
  end

  // ----------------------------------------
  // Fault flag.
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      fault <= 1'b0;
    else if (cmd_go & is_move & ~profiled)
      fault <= 1'b1;
    else if (cmd_go & (is_move | (op == OP_ZERO)) & running)
      fault <= 1'b1;
    else if (cmd_go & pwdata_i[CMD_CLRF_BIT])
      fault <= 1'b0;
  end

  // ----------------------------------------
  // Motion state.
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_IDLE;
      stopping <= 1'b0;
      dir_o <= 1'b0;
      home_start <= 1'b0;
      remaining <= '0;
    end
    else if (end_now)
    begin
      state <= ST_IDLE;
      stopping <= 1'b0;
      remaining <= '0;
    end
    else if (start_ok)
    begin
      stopping <= 1'b0;
      dir_o <= new_dir;
      unique case (op)
        OP_ABS:
        begin
          state <= ST_POS;
          remaining <= abs_mag[POS_W-1:0];
        end
        OP_REL:
        begin
          state <= ST_POS;
          remaining <= target;
        end
        OP_VEL: state <= ST_VEL;
        OP_HOME:
        begin
          state <= ST_HOME;
          home_start <= home_i;
        end
        default: state <= ST_IDLE;
      endcase
    end
    else
    begin
      if (soft_req)
        stopping <= 1'b1;
      if ((state == ST_POS) & step_go)
        remaining <= remaining - POS_W'(1);
    end
  end

  // ----------------------------------------
  // Speed ramp.
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      speed <= '0;
    else if (end_now | ~running)
      speed <= '0;
    else if (ramp_ovf & decel_now)
    begin
      if (speed > SPD_W'(floor_one))
        speed <= speed - SPD_W'(1);
    end
    else if (ramp_ovf & (speed < max_spd))
      speed <= speed + SPD_W'(1);
  end

  // ----------------------------------------
  // Position and step output.
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      position <= '0;
    else if (home_hit | zero_ok)
      position <= '0;
    else if (step_go)
      position <= dir_o ? position + POS_W'(1) : position - POS_W'(1);
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      step_o <= 1'b0;
    else
      step_o <= step_go;
  end

  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_move_unprofiled;
    cmd_go && is_move && !profiled;
  endsequence
  sequence s_home_start;
    start_ok && (op == OP_HOME);
  endsequence

  not_ready_a: assert property (s_move_unprofiled |=> (state == ST_IDLE) && fault)
    else $error("move without profile did not fault");
  accel_decel_a: assert property (cmd_go && (op == OP_PROFILE) && pwdata_i[CMD_LDACC_BIT]
    |=> (decel == $past(stage_acc)) && (accel == decel))
    else $error("profile accel did not set deceleration");
  home_dir_a: assert property (s_home_start |=> (state == ST_HOME) && (dir_o == $past(home_i)))
    else $error("home search started wrong way");
  home_zero_a: assert property (home_hit |=> (position == '0) && (state == ST_IDLE) && !step_o)
    else $error("home transition did not zero and stop");
  hard_stop_a: assert property (hard_cmd |=> (state == ST_IDLE) ##1 !step_o [*3])
    else $error("hard stop kept stepping");
  fwd_limit_a: assert property (running && dir_o && fwd_limit_i |=> (state == ST_IDLE) && !step_o)
    else $error("forward limit did not halt");
  pos_count_a: assert property (step_o && ($past(state) != ST_HOME)
    |-> position == ($past(dir_o) ? $past(position) + 1 : $past(position) - 1))
    else $error("position count does not follow step");
  rel_steps_a: assert property ((state == ST_POS) |-> (remaining != '0))
    else $error("positional move with nothing left");
  status_rd_a: assert property (pready_o && !pwrite_i && (paddr_i == OFS_STATUS)
    |-> prdata_o[ST_RUN_BIT] == $past(running))
    else $error("status run bit wrong");
  step_idle_a: assert property ((state == ST_IDLE) |=> !step_o)
    else $error("step pulse while idle");
endmodule
`default_nettype wire

// File: testbench/sam_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Step and direction drive with a home contact.
// ----------------------------------------
module sam_drive_model
#(
  parameter int HOME_AT = -200
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic step_i,
  input wire logic dir_i,
  output logic home_o,
  output var int phys_o,
  output var int count_o
);
  // The shaft moves one place per step pulse, in the sense of the direction level.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phys_o <= 0;
      count_o <= 0;
    end
    else if (step_i)
    begin
      phys_o <= dir_i ? phys_o + 1 : phys_o - 1;
      count_o <= count_o + 1;
    end
  end
  // The contact is closed while the shaft sits at or below the home point.
  assign home_o = (phys_o <= HOME_AT);
endmodule
`default_nettype wire

// File: testbench/test_stepper_axis_motion_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_stepper_axis_motion_control
  import sam_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] RUN = 32'h1 << ST_RUN_BIT;
  localparam logic [31:0] DIRB = 32'h1 << ST_DIR_BIT;
  localparam logic [31:0] FLT = 32'h1 << ST_FAULT_BIT;
  localparam logic [31:0] STP = 32'h1 << ST_STOPPING_BIT;
  localparam logic [31:0] MODE = 32'h3 << ST_MODE_LSB;
  localparam logic [31:0] CW = 32'h1 << CMD_DIR_BIT;
  localparam logic [31:0] LDM = 32'h1 << CMD_LDMAX_BIT;
  localparam logic [31:0] LDA = 32'h1 << CMD_LDACC_BIT;
  localparam logic [31:0] CLRF = 32'h1 << CMD_CLRF_BIT;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, home, step, dir;
  logic fwd_lim = 1'b0, rev_lim = 1'b0, soft_stop = 1'b0;
  int phys, steps, mark, err_count = 0, n_compared = 0;
  // ----------------------------------------
  // Clock, design and drive.
  // ----------------------------------------
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end
  sam_axis #(.TICK_CYCLES(20), .STEP_CLK_HZ(1000)) i_dut
  (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .home_i(home), .fwd_limit_i(fwd_lim),
    .rev_limit_i(rev_lim), .soft_stop_i(soft_stop), .step_o(step), .dir_o(dir)
  );
  sam_drive_model #(.HOME_AT(-200)) i_drive
  (
    .clk_i(clk_i), .resetn_i(resetn_i), .step_i(step), .dir_i(dir),
    .home_o(home), .phys_o(phys), .count_o(steps)
  );
  // ----------------------------------------
  // Bus access and comparison tasks.
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n == 200)
      check(32'h0, 32'h1, "bus answer");
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    check(r & m, e, what);
  endtask
  task automatic cmd(input sam_op_e op, input logic [31:0] extra);
    wr(OFS_CMD, 32'(op) | extra);
  endtask
  task automatic wait_idle();
    logic [31:0] r;
    int n;
    n = 0;
    r = RUN;
    while (r[ST_RUN_BIT] !== 1'b0 && n < 400)
    begin
      repeat (20) @(posedge clk_i);
      apb(1'b0, OFS_STATUS, 32'h0000_0000, r);
      n++;
    end
    check(r & RUN, 32'h0, "axis came to rest");
  endtask
  task automatic move(input sam_op_e op, input logic [31:0] extra, input logic [31:0] tgt,
                      input logic [31:0] e, input string what);
    wr(OFS_TARGET, tgt);
    cmd(op, extra);
    wait_idle();
    rd_chk(OFS_POS, ALL, e, what);
    check(32'(phys), e, "drive position");
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence.
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd_chk(OFS_STATUS, ALL, 32'h0000_0000, "status at reset");
    rd_chk(OFS_POS, ALL, 32'h0000_0000, "position at reset");
    rd_chk(12'h100, ALL, 32'h0000_0000, "unmapped read");
    check({31'h0, last_err}, 32'h1, "unmapped error");
    wr(OFS_TARGET, 32'h0000_0005);
    cmd(OP_ABS, 32'h0);
    rd_chk(OFS_STATUS, RUN | FLT, FLT, "move before profile");
    check(32'(steps), 32'h0, "no steps before profile");
    cmd(OP_NONE, CLRF);
    rd_chk(OFS_STATUS, FLT, 32'h0, "fault cleared");
    done("unprofiled");
    wr(OFS_MAXSPD, 32'h0000_00C9);
    wr(OFS_ACCEL, 32'h0000_012D);
    cmd(OP_PROFILE, LDM | LDA);
    rd_chk(OFS_MAXSPD, ALL, 32'h0000_00C9, "max speed");
    rd_chk(OFS_ACCEL, ALL, 32'h0000_012D, "accel");
    rd_chk(OFS_DECEL, ALL, 32'h0000_012D, "decel follows accel");
    wr(OFS_DECEL, 32'h0000_0064);
    rd_chk(OFS_DECEL, ALL, 32'h0000_0064, "own decel");
    wr(OFS_MAXSPD, 32'h0000_03E7);
    wr(OFS_ACCEL, 32'h0000_00FB);
    cmd(OP_PROFILE, LDA | 32'h0000_0080);
    rd_chk(OFS_MAXSPD, ALL, 32'h0000_00C9, "speed kept");
    rd_chk(OFS_ACCEL, ALL, 32'h0000_00FB, "new accel only");
    rd_chk(OFS_DECEL, ALL, 32'h0000_00FB, "decel overwritten");
    wr(OFS_DECEL, 32'h0000_00FA);
    done("profile");
    wr(OFS_TARGET, 32'h0000_0028);
    cmd(OP_ABS, 32'h0);
    rd_chk(OFS_STATUS, RUN | DIRB, RUN | DIRB, "running clockwise");
    cmd(OP_REL, CW);
    rd_chk(OFS_STATUS, FLT, FLT, "move while running");
    wait_idle();
    rd_chk(OFS_POS, ALL, 32'h0000_0028, "absolute position");
    check(32'(phys), 32'h0000_0028, "one pulse per step");
    cmd(OP_NONE, CLRF);
    move(OP_ABS, 32'h0, 32'hFFFF_FFF6, 32'hFFFF_FFF6, "absolute reverse");
    move(OP_REL, CW, 32'h0000_000F, 32'h0000_0005, "relative cw");
    move(OP_REL, 32'h0, 32'h0000_0003, 32'h0000_0002, "relative ccw");
    move(OP_ABS, 32'h0, 32'h0000_0002, 32'h0000_0002, "absolute in place");
    done("positioning");
    cmd(OP_VEL, CW);
    repeat (400) @(posedge clk_i);
    rd_chk(OFS_STATUS, RUN | MODE, RUN | 32'h0000_0040, "velocity mode");
    cmd(OP_SOFT, 32'h0);
    mark = steps;
    rd_chk(OFS_STATUS, STP, STP, "soft stop ramps");
    wait_idle();
    check(32'(steps > mark), 32'h1, "steps while ramping down");
    rd_chk(OFS_POS, ALL, 32'(phys), "position after velocity");
    cmd(OP_VEL, 32'h0);
    repeat (400) @(posedge clk_i);
    cmd(OP_HARD, 32'h0);
    repeat (2) @(posedge clk_i);
    mark = steps;
    repeat (100) @(posedge clk_i);
    check(32'(steps), 32'(mark), "no steps after hard stop");
    rd_chk(OFS_STATUS, RUN, 32'h0, "hard stop idle");
    done("velocity and stops");
    cmd(OP_VEL, CW);
    repeat (400) @(posedge clk_i);
    fwd_lim <= 1'b1;
    repeat (3) @(posedge clk_i);
    mark = steps;
    repeat (50) @(posedge clk_i);
    check(32'(steps), 32'(mark), "forward limit halts");
    cmd(OP_VEL, CW);
    rd_chk(OFS_STATUS, RUN, 32'h0, "forward limit blocks cw");
    cmd(OP_VEL, 32'h0);
    rd_chk(OFS_STATUS, RUN, RUN, "ccw allowed at forward limit");
    rev_lim <= 1'b1;
    wait_idle();
    fwd_lim <= 1'b0;
    rev_lim <= 1'b0;
    cmd(OP_VEL, 32'h0);
    repeat (400) @(posedge clk_i);
    soft_stop <= 1'b1;
    wait_idle();
    soft_stop <= 1'b0;
    rd_chk(OFS_POS, ALL, 32'(phys), "position after stops");
    move(OP_ABS, 32'h0, 32'h0000_0007, 32'h0000_0007, "absolute before zero");
    cmd(OP_ZERO, 32'h0);
    rd_chk(OFS_POS, ALL, 32'h0, "zero command clears position");
    done("limits");
    cmd(OP_HOME, 32'h0);
    rd_chk(OFS_STATUS, DIRB | MODE, 32'h0000_0060, "home ccw while open");
    wait_idle();
    rd_chk(OFS_POS, ALL, 32'h0, "home zeroes position");
    check({31'h0, home}, 32'h1, "stopped on closed contact");
    cmd(OP_HOME, 32'h0);
    rd_chk(OFS_STATUS, DIRB, DIRB, "home cw while closed");
    wait_idle();
    rd_chk(OFS_POS, ALL, 32'h0, "second home zeroes");
    check({31'h0, home}, 32'h0, "stopped on open contact");
    done("home");
    results();
  end
  // The whole sequence needs well under a third of this span.
  initial
  begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    results();
  end
endmodule
`default_nettype wire
